// ### core/skip_and_branch_unit.sv
module skip_and_branch_unit (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire flow_pkg::insn_t insn,
    input wire logic [flow_pkg::PC_W-1:0] pc_in,
    input wire logic [7:0] status_flags_in,
    output flow_pkg::result_t result
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        flow_pkg::result_t res;
    } state_t;

    state_t state;
    state_t next_state;
    logic taken;
    logic is_skip;
    // pc-wide view, lets the checks sign extend k by a cast instead of the datapath's replication
    typedef logic [flow_pkg::PC_W-1:0] pc_t;

    flow_cond u_cond (
        .insn(insn),
        .status_flags_register(status_flags_in),
        .taken(taken),
        .is_skip(is_skip)
    );

    // ------------------------------------------------------------
    // next pc and cycle count
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_state.res.done = 1'b0;
        if (insn.valid) begin
            next_state.res.done = 1'b1;
            next_state.res.taken = taken;
            // flags pass straight through: this unit never writes them
            next_state.res.status_flags_register = status_flags_in;
            if (!taken) begin
                next_state.res.pc = pc_in + flow_pkg::PC_STEP;
                next_state.res.cycles = flow_pkg::CYC_ONE;
            end else if (is_skip) begin
                if (insn.next_is_two_words) begin
                    next_state.res.pc = pc_in + flow_pkg::PC_SKIP_TWO;
                    next_state.res.cycles = flow_pkg::CYC_THREE;
                end else begin
                    next_state.res.pc = pc_in + flow_pkg::PC_SKIP_ONE;
                    next_state.res.cycles = flow_pkg::CYC_TWO;
                end
            end else begin
                // k is sign extended so backward branches wrap correctly
                next_state.res.pc = pc_in + {{(flow_pkg::PC_W - flow_pkg::K_W){insn.k[flow_pkg::K_W-1]}}, insn.k}
                    + flow_pkg::PC_STEP;
                next_state.res.cycles = flow_pkg::CYC_TWO;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state <= '{res: '{pc: flow_pkg::PC_RESET, cycles: '0, taken: 1'b0, done: 1'b0,
                status_flags_register: '0}};
        end else if (clk_en) begin
            state <= next_state;
        end
    end

    assign result = state.res;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_flags_kept;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid |=> result.status_flags_register == $past(status_flags_in);
    endproperty
    a_flags_kept: assert property (p_flags_kept) else $error("flags changed");

    property p_untaken_one;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && !taken
            |=> result.cycles == flow_pkg::CYC_ONE && result.pc == $past(pc_in) + flow_pkg::PC_STEP;
    endproperty
    a_untaken_one: assert property (p_untaken_one) else $error("untaken not one step");

    property p_skip_short;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && taken && is_skip && !insn.next_is_two_words
            |=> result.pc == $past(pc_in) + flow_pkg::PC_SKIP_ONE && result.cycles == flow_pkg::CYC_TWO;
    endproperty
    a_skip_short: assert property (p_skip_short) else $error("short skip wrong");

    property p_skip_long;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && taken && is_skip && insn.next_is_two_words
            |=> result.pc == $past(pc_in) + flow_pkg::PC_SKIP_TWO && result.cycles == flow_pkg::CYC_THREE;
    endproperty
    a_skip_long: assert property (p_skip_long) else $error("long skip wrong");

    property p_branch_two;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && taken && !is_skip |=> result.cycles == flow_pkg::CYC_TWO && result.taken;
    endproperty
    a_branch_two: assert property (p_branch_two) else $error("branch cycles wrong");

    property p_eq_zero;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_BRANCH_IF_EQUAL && !insn.ne
            |=> result.taken == $past(status_flags_in[flow_pkg::FLAG_ZERO]);
    endproperty
    a_eq_zero: assert property (p_eq_zero) else $error("equal branch wrong");

    property p_ne_zero;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_BRANCH_IF_EQUAL && insn.ne
            |=> result.taken == !$past(status_flags_in[flow_pkg::FLAG_ZERO]);
    endproperty
    a_ne_zero: assert property (p_ne_zero) else $error("not-equal branch wrong");

    property p_reg_set;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_SKIP_IF_REG_BIT_SET
            |=> result.taken == $past(insn.source_working_register[insn.bit_sel]);
    endproperty
    a_reg_set: assert property (p_reg_set) else $error("register set skip wrong");

    property p_io_clear;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_SKIP_IF_IO_BIT_CLEAR
            |=> result.taken == !$past(insn.io_value[insn.bit_sel]);
    endproperty
    a_io_clear: assert property (p_io_clear) else $error("io clear skip wrong");

    // ------------------------------------------------------------
    // per-rule checks on the remaining conditions, branch target and cycles, the done pulse and the clk_en hold
    // ------------------------------------------------------------
    property p_reg_clear;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_SKIP_IF_REG_BIT_CLEAR
            |=> result.taken == !$past(insn.source_working_register[insn.bit_sel]);
    endproperty
    a_reg_clear: assert property (p_reg_clear) else $error("register clear skip wrong");

    property p_io_set;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_SKIP_IF_IO_BIT_SET
            |=> result.taken == $past(insn.io_value[insn.bit_sel]);
    endproperty
    a_io_set: assert property (p_io_set) else $error("io set skip wrong");

    property p_flag_set;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_BRANCH_IF_FLAG_SET
            |=> result.taken == $past(status_flags_in[insn.bit_sel]);
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag set branch wrong");

    property p_flag_clear;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_BRANCH_IF_FLAG_CLEAR
            |=> result.taken == !$past(status_flags_in[insn.bit_sel]);
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag clear branch wrong");

    property p_branch_target;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && taken && !is_skip
            |=> result.pc == $past(pc_in) + $past(pc_t'($signed(insn.k))) + flow_pkg::PC_STEP;
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("branch target wrong");

    property p_branch_untaken;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && !taken && !is_skip && insn.op != flow_pkg::OP_NONE
            |=> result.cycles == flow_pkg::CYC_ONE && !result.taken;
    endproperty
    a_branch_untaken: assert property (p_branch_untaken) else $error("untaken branch cycles wrong");

    property p_eq_in_sequence;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && insn.op == flow_pkg::OP_BRANCH_IF_EQUAL && !taken
            |=> result.pc == $past(pc_in) + flow_pkg::PC_STEP;
    endproperty
    a_eq_in_sequence: assert property (p_eq_in_sequence) else $error("equal branch left sequence");

    property p_skip_not_single;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid && taken && is_skip
            |=> result.cycles != flow_pkg::CYC_ONE && result.taken;
    endproperty
    a_skip_not_single: assert property (p_skip_not_single) else $error("taken skip one cycle");

    property p_done_on_issue;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && insn.valid
            |=> result.done;
    endproperty
    a_done_on_issue: assert property (p_done_on_issue) else $error("issue gave no done");

    property p_done_drops;
        @(posedge clk_sys) disable iff (!rst_b)
            clk_en && !insn.valid
            |=> !result.done;
    endproperty
    a_done_drops: assert property (p_done_drops) else $error("done held without issue");

    property p_hold;
        @(posedge clk_sys) disable iff (!rst_b)
            !clk_en |=> $stable(result);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved while disabled");
endmodule : skip_and_branch_unit

// ### core/flow_pkg.sv
package flow_pkg;
    localparam int PC_W = 16;
    localparam int K_W = 7;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam logic [PC_W-1:0] PC_STEP = 16'h0001;
    localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
    localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;
    localparam logic [1:0] CYC_THREE = 2'h3;
    localparam int FLAG_ZERO = 1;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SKIP_IF_REG_BIT_CLEAR,
        OP_SKIP_IF_REG_BIT_SET,
        OP_SKIP_IF_IO_BIT_CLEAR,
        OP_SKIP_IF_IO_BIT_SET,
        OP_BRANCH_IF_FLAG_SET,
        OP_BRANCH_IF_FLAG_CLEAR,
        OP_BRANCH_IF_EQUAL
    } op_t;

    // one issued instruction; not-equal is OP_BRANCH_IF_EQUAL with ne set, taken on a clear zero flag
    typedef struct packed {
        logic valid;
        op_t op;
        logic ne;
        logic [2:0] bit_sel;
        logic [7:0] source_working_register;
        logic [7:0] io_value;
        logic [K_W-1:0] k;
        logic next_is_two_words;
    } insn_t;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [1:0] cycles;
        logic taken;
        logic done;
        logic [7:0] status_flags_register;
    } result_t;
endpackage : flow_pkg

// ### core/flow_cond.sv
module flow_cond (
    input wire flow_pkg::insn_t insn,
    input wire logic [7:0] status_flags_register,
    output logic taken,
    output logic is_skip
);
    function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
        pick = v[s];
    endfunction : pick

    always_comb begin
        taken = 1'b0;
        is_skip = 1'b0;
        case (insn.op)
            flow_pkg::OP_SKIP_IF_REG_BIT_CLEAR: begin
                is_skip = 1'b1;
                taken = !pick(insn.source_working_register, insn.bit_sel);
            end
            flow_pkg::OP_SKIP_IF_REG_BIT_SET: begin
                is_skip = 1'b1;
                taken = pick(insn.source_working_register, insn.bit_sel);
            end
            flow_pkg::OP_SKIP_IF_IO_BIT_CLEAR: begin
                is_skip = 1'b1;
                taken = !pick(insn.io_value, insn.bit_sel);
            end
            flow_pkg::OP_SKIP_IF_IO_BIT_SET: begin
                is_skip = 1'b1;
                taken = pick(insn.io_value, insn.bit_sel);
            end
            flow_pkg::OP_BRANCH_IF_FLAG_SET: taken = pick(status_flags_register, insn.bit_sel);
            flow_pkg::OP_BRANCH_IF_FLAG_CLEAR: taken = !pick(status_flags_register, insn.bit_sel);
            flow_pkg::OP_BRANCH_IF_EQUAL: begin
                if (insn.ne) begin
                    taken = !status_flags_register[flow_pkg::FLAG_ZERO];
                end else begin
                    taken = status_flags_register[flow_pkg::FLAG_ZERO];
                end
            end
            default: taken = 1'b0;
        endcase
    end
endmodule : flow_cond

// ### dv/skip_and_branch_unit_bench.sv
module skip_and_branch_unit_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b0;
    flow_pkg::insn_t insn = '0;
    logic [15:0] pc_in = 16'h0000;
    logic [7:0] status_flags_in = 8'h00;
    flow_pkg::result_t result;
    flow_pkg::result_t held;
    flow_pkg::result_t q[$];
    logic en_q;
    int err_total = 0;
    int checks_done = 0;
    int seed = 87;

    always #2 clk_sys = ~clk_sys;

    skip_and_branch_unit dut (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .insn(insn),
        .pc_in(pc_in), .status_flags_in(status_flags_in), .result(result));

    task automatic chk(input logic [27:0] seen, input logic [27:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // reference: expected outcome of one issue
    // ----------------------------------------
    function automatic flow_pkg::result_t model(flow_pkg::insn_t i, logic [15:0] p, logic [7:0] f);
        flow_pkg::result_t r;
        logic t;
        logic br;
        t = 1'b0;
        br = 1'b0;
        case (i.op)
            flow_pkg::OP_SKIP_IF_REG_BIT_CLEAR: t = !i.source_working_register[i.bit_sel];
            flow_pkg::OP_SKIP_IF_REG_BIT_SET: t = i.source_working_register[i.bit_sel];
            flow_pkg::OP_SKIP_IF_IO_BIT_CLEAR: t = !i.io_value[i.bit_sel];
            flow_pkg::OP_SKIP_IF_IO_BIT_SET: t = i.io_value[i.bit_sel];
            flow_pkg::OP_BRANCH_IF_FLAG_SET: {br, t} = {1'b1, f[i.bit_sel]};
            flow_pkg::OP_BRANCH_IF_FLAG_CLEAR: {br, t} = {1'b1, !f[i.bit_sel]};
            flow_pkg::OP_BRANCH_IF_EQUAL: {br, t} = {1'b1, f[flow_pkg::FLAG_ZERO] ^ i.ne};
            default: ;
        endcase
        r.taken = t;
        r.done = 1'b1;
        r.status_flags_register = f;
        if (!t) {r.pc, r.cycles} = {p + 16'h0001, 2'h1};
        else if (br) {r.pc, r.cycles} = {p + {{9{i.k[6]}}, i.k} + 16'h0001, 2'h2};
        else if (i.next_is_two_words) {r.pc, r.cycles} = {p + 16'h0003, 2'h3};
        else {r.pc, r.cycles} = {p + 16'h0002, 2'h2};
        return r;
    endfunction : model

    // ----------------------------------------
    // monitor: a frozen edge neither reports nor changes the result
    // ----------------------------------------
    always @(posedge clk_sys) en_q <= clk_en;

    always @(negedge clk_sys) begin
        if (rst_b && en_q && result.done !== 1'b0) begin
            if (q.size() == 0) chk({27'h0, result.done}, 28'h0);
            else begin
                held = q.pop_front();
                chk({27'h0, result.done}, {27'h0, held.done});
                chk({12'h0, result.pc}, {12'h0, held.pc});
                chk({26'h0, result.cycles}, {26'h0, held.cycles});
                chk({27'h0, result.taken}, {27'h0, held.taken});
                chk({20'h0, result.status_flags_register}, {20'h0, held.status_flags_register});
            end
        end
        if (rst_b && en_q === 1'b0) chk(result, held);
        held = result;
    end

    // ----------------------------------------
    // driver: random issues, back to back, with clk_en gaps
    // ----------------------------------------
    initial begin
        flow_pkg::insn_t n;
        logic [15:0] p;
        logic [7:0] f;
        logic en;
        repeat (20) @(posedge clk_sys);
        chk(result, 28'h0);
        rst_b <= 1'b1;
        for (int c = 0; c < 800; c++) begin
            @(posedge clk_sys);
            n = $random(seed);
            p = $random(seed);
            f = $random(seed);
            en = ($random(seed) & 3) != 0;
            insn <= n;
            pc_in <= p;
            status_flags_in <= f;
            clk_en <= en;
            if (en && n.valid) q.push_back(model(n, p, f));
        end
        @(posedge clk_sys);
        insn <= '0;
        clk_en <= 1'b1;
        // bounded drain so a lost result cannot hang the run
        for (int w = 0; w < 10 && q.size() != 0; w++) @(posedge clk_sys);
        if (q.size() != 0) err_total++;
        give_verdict();
    end
endmodule : skip_and_branch_unit_bench
